// *** logic/reset_stop_recovery_ctrl.v ***
// Function
// - Five sources start a system reset
// - Stop wake sources start stop recovery
// - Hold 66 oscillator then 16 clocks
// - Reset start forces all GPIO inputs
// - Core idle; system clock after oscillator count
// - System reset reloads defined register values
// - Core fetches vector at 0002H/0003H
// - Power or brownout outranks every source
// - Normal/halt sources give system reset
// - In stop, power/pin/debug pin reset fully
// - Power counter then crystal counter
// - Power sequence sets power cause flag
// - Brownout holds reset, then full sequence
// - Option bit keeps brownout alive in stop
// - Watchdog reset option, sets watchdog flag
// - Pin low four clocks; held while low
// - Pin reset sets external cause flag
// - Debugger request self-clears, sets power flag
// - Stop recovery touches only cause register
// - Stop recovery sets stop cause flag
// - Stop watchdog sets both; interrupt afterwards if watchdog reset option clear and intEnabled high
// - GPIO edge wakes; short glitches rejected
`timescale 1ns/10ps
`include "reset_stop_recovery_ctrl_map.vh"

module reset_stop_recovery_ctrl #(
   parameter GPIO_W = 8,
   parameter WDO_CYCLES = `RSR_WDO_CYCLES,
   parameter SYS_CYCLES = `RSR_SYS_CYCLES
) (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // Reset sources
   input wire porDetect,
   input wire brownoutDetect,
   input wire watchdogTimeout,
   input wire watchdogOscTick,
   input wire resetPinN,
   input wire debugPinN,
   input wire [GPIO_W-1:0] gpioIn,
   // Core status
   input wire stopEnter,
   input wire intEnabled,
   // Reset outputs
   output reg coreReset,
   output reg periphReset,
   output reg gpioForceInput,
   output reg sysClkEnable,
   output reg stopMode,
   output reg vectorFetch,
   output reg [15:0] vectorAddr,
   output reg watchdogIrq
);

   localparam ST_RUN = 2'd0;
   localparam ST_STOP = 2'd1;
   localparam ST_WDO = 2'd2;
   localparam ST_SYS = 2'd3;
   localparam integer GC = `RSR_GLITCH_CYCLES;

   reg [1:0] state;
   reg [1:0] next_state;
   reg [6:0] wdoCnt;
   reg [4:0] sysCnt;
   reg kindSys;
   reg next_kindSys;
   reg [3:0] pend;
   reg [3:0] next_pend;
   reg irqPend;
   reg next_irqPend;
   reg [3:0] cause;
   reg [1:0] option;
   reg debugRst;
   reg [GPIO_W-1:0] wakeEn;
   reg restart;
   reg seqRelease;

   // Bus data phase tracking
   reg busPend;
   reg busWrite;
   reg [3:0] busAddr;
   reg busHit;

   // Pin synchronisers
   reg xrstSync1;
   reg xrstSync2;
   reg [2:0] lowCnt;
   reg dpinSync1;
   reg dpinSync2;
   wire [GPIO_W-1:0] gEvt;

   wire inStop;
   wire boEff;
   wire pwrReq;
   wire xrstNew;
   wire xrstHeld;
   wire wdReset;
   wire debugReq;
   wire dpinReq;
   wire wakeHit;
   wire stopReq;
   wire seqDone;
   wire busTake;
   wire [31:0] rdata;
   wire [3:0] causeClr;

   assign inStop = (state == ST_STOP);

   // Brownout watched in stop only when the option allows
   assign boEff = brownoutDetect &
      (~inStop | option[`RSR_OPT_BOSTOP_BIT]);
   assign pwrReq = porDetect | boEff;

   // Reset pin: synchronise then count consecutive low cycles
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         xrstSync1 <= 1'b1;
         xrstSync2 <= 1'b1;
         dpinSync1 <= 1'b1;
         dpinSync2 <= 1'b1;
         lowCnt <= 3'h0;
      end else begin
         xrstSync1 <= resetPinN;
         xrstSync2 <= xrstSync1;
         dpinSync1 <= debugPinN;
         dpinSync2 <= dpinSync1;
         if (xrstSync2) begin
            lowCnt <= 3'h0;
         end else if (lowCnt != `RSR_XRST_MIN_CYCLES) begin
            lowCnt <= lowCnt + 3'h1;
         end
      end
   end

   // Accepted on the fourth low cycle; held while still low
   assign xrstNew = ~xrstSync2 &
      (lowCnt == `RSR_XRST_MIN_CYCLES - 1);
   assign xrstHeld = ~xrstSync2 &
      (lowCnt == `RSR_XRST_MIN_CYCLES);

   // GPIO wake filters, one per pin
   genvar gi;
   generate
      for (gi = 0; gi < GPIO_W; gi = gi + 1) begin : gpioFilt
         reg gSync1;
         reg gSync2;
         reg gRef;
         reg [3:0] gCnt;
         assign gEvt[gi] = (gSync2 != gRef) &
            (gCnt == GC - 1);
         always @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               gSync1 <= 1'b0;
               gSync2 <= 1'b0;
               gRef <= 1'b0;
               gCnt <= 4'h0;
            end else begin
               gSync1 <= gpioIn[gi];
               gSync2 <= gSync1;
               if (gSync2 == gRef) begin
                  gCnt <= 4'h0;
               end else if (gEvt[gi] | ~inStop) begin
                  gRef <= gSync2;
                  gCnt <= 4'h0;
               end else begin
                  gCnt <= gCnt + 4'h1;
               end
            end
         end
      end
   endgenerate

   // Request decode
   assign wdReset = watchdogTimeout & ~inStop &
      option[`RSR_OPT_WDRST_BIT];
   assign debugReq = debugRst & ~inStop;
   assign dpinReq = inStop & ~dpinSync2;
   assign wakeHit = |(gEvt & wakeEn);
   assign stopReq = inStop & (watchdogTimeout | wakeHit);
   assign seqDone = (state == ST_SYS) &
      (sysCnt == SYS_CYCLES - 1) & ~xrstHeld;

   // Sequence control and cause collection
   always @* begin
      next_state = state;
      next_kindSys = kindSys;
      next_pend = pend;
      next_irqPend = irqPend;
      restart = 1'b0;
      seqRelease = 1'b0;
      if (pwrReq) begin
         restart = 1'b1;
         next_kindSys = 1'b1;
         next_pend = 4'h0;
         next_pend[`RSR_CAUSE_PWR_BIT] = 1'b1;
         next_irqPend = 1'b0;
      end else if (xrstNew | wdReset | debugReq | dpinReq) begin
         restart = 1'b1;
         if (~next_kindSys | (state == ST_RUN)) begin
            next_pend = 4'h0;
            next_irqPend = 1'b0;
         end
         next_kindSys = 1'b1;
         if (xrstNew) begin
            next_pend[`RSR_CAUSE_XRST_BIT] = 1'b1;
         end
         if (wdReset) begin
            next_pend[`RSR_CAUSE_WD_BIT] = 1'b1;
         end
         if (debugReq) begin
            next_pend[`RSR_CAUSE_PWR_BIT] = 1'b1;
         end
      end else if (stopReq) begin
         restart = 1'b1;
         next_kindSys = 1'b0;
         next_pend = 4'h0;
         next_pend[`RSR_CAUSE_STOP_BIT] = 1'b1;
         if (watchdogTimeout) begin
            next_pend[`RSR_CAUSE_WD_BIT] = 1'b1;
            next_irqPend = ~option[`RSR_OPT_WDRST_BIT];
         end else begin
            next_irqPend = 1'b0;
         end
      end
      if (restart) begin
         next_state = ST_WDO;
      end else begin
         case (state)
            ST_RUN: begin
               if (stopEnter) begin
                  next_state = ST_STOP;
               end
            end
            ST_STOP: begin
               next_state = ST_STOP;
            end
            ST_WDO: begin
               if (watchdogOscTick & (wdoCnt == WDO_CYCLES - 1)) begin
                  next_state = ST_SYS;
               end
            end
            ST_SYS: begin
               if (seqDone) begin
                  next_state = ST_RUN;
                  seqRelease = 1'b1;
               end
            end
            default: begin
               next_state = ST_WDO;
            end
         endcase
      end
   end

   // Oscillator count then system clock count
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= ST_WDO;
         wdoCnt <= 7'h0;
         sysCnt <= 5'h0;
         kindSys <= 1'b1;
         pend <= 4'h1;
         irqPend <= 1'b0;
      end else begin
         state <= next_state;
         kindSys <= next_kindSys;
         pend <= next_pend;
         irqPend <= next_irqPend;
         if (restart | (next_state != ST_WDO)) begin
            wdoCnt <= 7'h0;
         end else if (watchdogOscTick) begin
            wdoCnt <= wdoCnt + 7'h1;
         end
         if (next_state != ST_SYS) begin
            sysCnt <= 5'h0;
         end else if (state == ST_SYS) begin
            if (sysCnt != SYS_CYCLES - 1) begin
               sysCnt <= sysCnt + 5'h1;
            end
         end
      end
   end

   // Reset outputs follow the next state
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         coreReset <= 1'b1;
         periphReset <= 1'b1;
         gpioForceInput <= 1'b1;
         sysClkEnable <= 1'b0;
         stopMode <= 1'b0;
         vectorFetch <= 1'b0;
         vectorAddr <= `RSR_VECTOR_ADDR;
         watchdogIrq <= 1'b0;
      end else begin
         coreReset <= next_state[1];
         periphReset <= next_state[1] & next_kindSys;
         gpioForceInput <= next_state[1] & next_kindSys;
         sysClkEnable <= (next_state == ST_SYS) |
            (next_state == ST_RUN);
         stopMode <= (next_state == ST_STOP);
         vectorFetch <= seqRelease;
         vectorAddr <= `RSR_VECTOR_ADDR;
         watchdogIrq <= seqRelease & irqPend & intEnabled;
      end
   end

   // Bus address phase capture
   assign busTake = hsel & htrans[1] & hready & hreadyout;
   assign causeClr = (busPend & busWrite & busHit &
      (busAddr == `RSR_OFF_CAUSE)) ? hwdata[3:0] : 4'h0;

   // Read mux
   assign rdata =
      ~busHit ? 32'h0 :
      (busAddr == `RSR_OFF_OPTION) ? {30'h0, option} :
      (busAddr == `RSR_OFF_DEBUG) ? {31'h0, debugRst} :
      (busAddr == `RSR_OFF_CAUSE) ?
         {22'h0, state, 3'h0, kindSys, cause} :
      (busAddr == `RSR_OFF_WAKE) ?
         {{(32-GPIO_W){1'b0}}, wakeEn} : 32'h0;

   // One wait state per transfer; response always OKAY
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busPend <= 1'b0;
         busWrite <= 1'b0;
         busAddr <= 4'h0;
         busHit <= 1'b0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0;
      end else begin
         hresp <= 1'b0;
         if (busPend) begin
            busPend <= 1'b0;
            hreadyout <= 1'b1;
            if (~busWrite) begin
               hrdata <= rdata;
            end
         end else if (busTake) begin
            busPend <= 1'b1;
            busWrite <= hwrite;
            busAddr <= haddr[3:0];
            busHit <= (haddr[31:4] == 28'h0) & (haddr[1:0] == 2'h0);
            hreadyout <= 1'b0;
         end
      end
   end

   // Software registers
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         option <= `RSR_OPT_RESET;
         debugRst <= 1'b0;
         wakeEn <= `RSR_WAKE_RESET;
         cause <= 4'h0;
      end else begin
         if (busPend & busWrite & busHit) begin
            if (busAddr == `RSR_OFF_OPTION) begin
               option <= hwdata[1:0];
            end
            if (busAddr == `RSR_OFF_WAKE) begin
               wakeEn <= hwdata[GPIO_W-1:0];
            end
         end
         // Debugger request survives system reset but clears itself
         if (restart & debugReq) begin
            debugRst <= 1'b0;
         end else if (busPend & busWrite & busHit &
            (busAddr == `RSR_OFF_DEBUG)) begin
            debugRst <= hwdata[`RSR_DEBUG_RST_BIT];
         end
         // Defined values reload on system reset only
         if (restart & next_kindSys) begin
            wakeEn <= `RSR_WAKE_RESET;
         end
         // Causes cleared at start, set at release; set beats clear
         if (seqRelease) begin
            cause <= (cause & ~causeClr) | pend;
         end else if (restart & (state[1] == 1'b0)) begin
            cause <= 4'h0;
         end else begin
            cause <= cause & ~causeClr;
         end
      end
   end

endmodule

// *** logic/reset_stop_recovery_ctrl_map.vh ***
`ifndef RESET_STOP_RECOVERY_CTRL_MAP_VH
`define RESET_STOP_RECOVERY_CTRL_MAP_VH

// Register byte offsets
`define RSR_OFF_OPTION 4'h0
`define RSR_OFF_DEBUG 4'h4
`define RSR_OFF_CAUSE 4'h8
`define RSR_OFF_WAKE 4'hc

// Option register fields
`define RSR_OPT_WDRST_BIT 0
`define RSR_OPT_BOSTOP_BIT 1
`define RSR_OPT_RESET 2'h1

// Debugger control field
`define RSR_DEBUG_RST_BIT 0

// Cause register fields
`define RSR_CAUSE_PWR_BIT 0
`define RSR_CAUSE_STOP_BIT 1
`define RSR_CAUSE_WD_BIT 2
`define RSR_CAUSE_XRST_BIT 3
`define RSR_CAUSE_KIND_BIT 4
`define RSR_CAUSE_STATE_LSB 8

// Wake enable reset value
`define RSR_WAKE_RESET 8'h00

// Sequence lengths and timing
`define RSR_WDO_CYCLES 66
`define RSR_SYS_CYCLES 16
`define RSR_XRST_MIN_CYCLES 4
`define RSR_CLK_PERIOD_NS 5
`define RSR_GLITCH_NS 10
`define RSR_GLITCH_CYCLES \
   ((`RSR_GLITCH_NS + `RSR_CLK_PERIOD_NS - 1) / `RSR_CLK_PERIOD_NS)

// Reset vector location
`define RSR_VECTOR_ADDR 16'h0002

`endif

// *** bench/wdog_osc_model.sv ***
`timescale 1ns/10ps
// Watchdog RC oscillator as seen by the controller: a slow free-running tick
module wdog_osc_model #(
   parameter DIV = 3
) (
   // Clock
   input wire ref_clk,
   // Oscillator tick
   output logic watchdogOscTick
);
   int phase = 0;
   // Runs free through reset, as the real oscillator keeps running
   always @(posedge ref_clk) begin
      phase <= (phase + 1) % DIV;
      watchdogOscTick <= (phase == DIV - 1);
   end
endmodule

// *** bench/reset_stop_recovery_ctrl_sva.sv ***
`timescale 1ns/10ps
module rsr_checker #(
   parameter GPIO_W = 8,
   parameter WDO_CYCLES = 66,
   parameter SYS_CYCLES = 16
) (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Watched inputs
   input wire porDetect,
   input wire resetPinN,
   input wire watchdogOscTick,
   // Watched outputs
   input wire coreReset,
   input wire periphReset,
   input wire gpioForceInput,
   input wire sysClkEnable,
   input wire vectorFetch,
   input wire [15:0] vectorAddr,
   input wire watchdogIrq
);
   reg [15:0] tickCnt;
   // Oscillator ticks seen while the system clock is off
   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         tickCnt <= 16'h0000;
      else if (sysClkEnable)
         tickCnt <= 16'h0000;
      else if (watchdogOscTick && tickCnt != 16'hffff)
         tickCnt <= tickCnt + 16'h0001;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_vector_fixed: assert property (vectorAddr == 16'h0002)
      else $error("vector address wrong");
   a_fetch_release: assert property (
      vectorFetch |-> !coreReset && $past(coreReset))
      else $error("fetch without release");
   a_fetch_single: assert property (vectorFetch |=> !vectorFetch)
      else $error("fetch pulse too long");
   a_crystal_count: assert property (
      vectorFetch |-> $past(sysClkEnable, 16))
      else $error("crystal count too short");
   a_osc_count: assert property (
      $rose(sysClkEnable) |-> tickCnt >= WDO_CYCLES - 1)
      else $error("oscillator count too short");
   a_clock_in_reset: assert property ($rose(sysClkEnable) |-> coreReset)
      else $error("clock started outside reset");
   a_gpio_input: assert property ($rose(periphReset) |-> gpioForceInput)
      else $error("pins not forced to input");
   a_stop_partial: assert property (
      coreReset && !periphReset |-> !gpioForceInput)
      else $error("recovery touched pins");
   a_power_hold: assert property (
      porDetect |=> coreReset && periphReset)
      else $error("power event not holding reset");
   a_pin_held: assert property (!resetPinN [*8] |=> coreReset)
      else $error("pin low without reset");
   a_irq_after: assert property (watchdogIrq |-> vectorFetch)
      else $error("interrupt not at release");
   c_irq: cover property (watchdogIrq);
   c_stop: cover property ($rose(coreReset) && !periphReset);
   c_pin: cover property (!resetPinN [*8]);
endmodule
bind reset_stop_recovery_ctrl rsr_checker #(.GPIO_W(GPIO_W),
   .WDO_CYCLES(WDO_CYCLES), .SYS_CYCLES(SYS_CYCLES)) u_chk (.ref_clk, .rst,
   .porDetect, .resetPinN, .watchdogOscTick, .coreReset, .periphReset,
   .gpioForceInput, .sysClkEnable, .vectorFetch, .vectorAddr, .watchdogIrq);

// *** bench/reset_stop_recovery_ctrl_test.sv ***
`timescale 1ns/10ps
module reset_stop_recovery_ctrl_test;
   // Stimulus and observed signals
   logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic porDetect = 1'b1, brownoutDetect = 1'b0, watchdogTimeout = 1'b0;
   logic resetPinN = 1'b1, debugPinN = 1'b1, stopEnter = 1'b0;
   logic intEnabled = 1'b0, irqSeen;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [7:0] gpioIn = 8'h00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [15:0] vectorAddr;
   logic hreadyout, hresp, watchdogOscTick, coreReset, periphReset;
   logic gpioForceInput, sysClkEnable, stopMode, vectorFetch, watchdogIrq;
   int num_errors = 0, n_tests = 0;
   // Clock, oscillator and device
   always #2.5 ref_clk = ~ref_clk;
   wdog_osc_model u_osc (.ref_clk, .watchdogOscTick);
   reset_stop_recovery_ctrl u_dut (.ref_clk, .rst, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp, .porDetect, .brownoutDetect, .watchdogTimeout,
      .watchdogOscTick, .resetPinN, .debugPinN, .gpioIn, .stopEnter,
      .intEnabled, .coreReset, .periphReset, .gpioForceInput, .sysClkEnable,
      .stopMode, .vectorFetch, .vectorAddr, .watchdogIrq);
   task give_verdict;
      $display("checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // Single AHB word transfer; holds each phase until hready is seen high
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   task rchk(input string what, input logic [31:0] a, m, exp);
      ahb(1'b0, a, 32'h0);
      chk(what, exp, rd & m);
   endtask
   // Wait a bounded time for the core to be released
   task wait_fetch(input int lim);
      int i;
      i = 0;
      @(posedge ref_clk);
      while (vectorFetch !== 1'b1 && i < lim) begin
         @(posedge ref_clk);
         i++;
      end
      irqSeen = watchdogIrq;
      chk("release", 32'h1, {31'h0, vectorFetch});
      chk("vector", 32'h2, {16'h0, vectorAddr});
   endtask
   task stop_in;
      @(posedge ref_clk);
      stopEnter <= 1'b1;
      @(posedge ref_clk);
      stopEnter <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk("stopMode", 32'h1, {31'h0, stopMode});
   endtask
   task wd_pulse;
      @(posedge ref_clk);
      watchdogTimeout <= 1'b1;
      @(posedge ref_clk);
      watchdogTimeout <= 1'b0;
   endtask
   task t_power;
      repeat (40) @(posedge ref_clk);
      chk("held", 32'h1, {31'h0, coreReset});
      chk("sysClk", 32'h0, {31'h0, sysClkEnable});
      chk("gpioIn", 32'h1, {31'h0, gpioForceInput});
      chk("periph", 32'h1, {31'h0, periphReset});
      porDetect <= 1'b0;
      wait_fetch(400);
      rchk("option", 32'h0, 32'h3, 32'h1);
      rchk("wake", 32'hc, 32'hff, 32'h0);
      rchk("cause", 32'h8, 32'h1f, 32'h11);
      rchk("unmapped", 32'h10, 32'hffffffff, 32'h0);
   endtask
   task t_pin;
      resetPinN <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetPinN <= 1'b1;
      repeat (12) @(posedge ref_clk);
      chk("short pin", 32'h0, {31'h0, coreReset});
      resetPinN <= 1'b0;
      repeat (400) @(posedge ref_clk);
      chk("pin held", 32'h1, {31'h0, coreReset});
      resetPinN <= 1'b1;
      wait_fetch(20);
      rchk("cause", 32'h8, 32'h1f, 32'h18);
   endtask
   task t_brown;
      brownoutDetect <= 1'b1;
      repeat (20) @(posedge ref_clk);
      resetPinN <= 1'b0;
      repeat (20) @(posedge ref_clk);
      resetPinN <= 1'b1;
      repeat (300) @(posedge ref_clk);
      chk("brownout", 32'h1, {31'h0, coreReset});
      brownoutDetect <= 1'b0;
      wait_fetch(400);
      rchk("cause", 32'h8, 32'h1f, 32'h11);
   endtask
   task t_sys;
      wd_pulse;
      wait_fetch(400);
      rchk("cause", 32'h8, 32'h1f, 32'h14);
      ahb(1'b1, 32'h4, 32'h1);
      wait_fetch(400);
      rchk("debugger", 32'h4, 32'h1, 32'h0);
      rchk("cause", 32'h8, 32'h1f, 32'h11);
   endtask
   task t_stop;
      ahb(1'b1, 32'hc, 32'h1);
      stop_in;
      gpioIn <= 8'h01;
      @(posedge ref_clk);
      gpioIn <= 8'h00;
      repeat (10) @(posedge ref_clk);
      chk("glitch", 32'h0, {31'h0, coreReset});
      gpioIn <= 8'h02;
      repeat (10) @(posedge ref_clk);
      chk("masked pin", 32'h0, {31'h0, coreReset});
      gpioIn <= 8'h03;
      wait_fetch(400);
      rchk("wake kept", 32'hc, 32'hff, 32'h1);
      rchk("cause", 32'h8, 32'h1f, 32'h02);
      ahb(1'b1, 32'h0, 32'h0);
      intEnabled <= 1'b1;
      stop_in;
      wd_pulse;
      repeat (5) @(posedge ref_clk);
      chk("stop core", 32'h1, {31'h0, coreReset});
      chk("stop periph", 32'h0, {31'h0, periphReset});
      wait_fetch(400);
      chk("irq", 32'h1, {31'h0, irqSeen});
      rchk("cause", 32'h8, 32'h1f, 32'h06);
      ahb(1'b1, 32'h0, 32'h1);
      stop_in;
      debugPinN <= 1'b0;
      repeat (10) @(posedge ref_clk);
      debugPinN <= 1'b1;
      wait_fetch(400);
      rchk("cause", 32'h8, 32'h1f, 32'h10);
      stop_in;
      brownoutDetect <= 1'b1;
      repeat (10) @(posedge ref_clk);
      chk("stop brownout off", 32'h0, {31'h0, coreReset});
      brownoutDetect <= 1'b0;
      ahb(1'b1, 32'h0, 32'h3);
      brownoutDetect <= 1'b1;
      repeat (10) @(posedge ref_clk);
      chk("stop brownout on", 32'h1, {31'h0, coreReset});
      brownoutDetect <= 1'b0;
      wait_fetch(400);
      rchk("cause", 32'h8, 32'h1f, 32'h11);
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      t_power;
      t_pin;
      t_brown;
      t_sys;
      t_stop;
      give_verdict;
   end
   // Hang guard, well above the expected few thousand cycles
   initial begin
      #100000;
      num_errors++;
      give_verdict;
   end
endmodule
